// ===== design/pwmctl_top.sv
/*
 * pwmctl_top: control-register front end of a 12-bit waveform timer.
 * Holds the five control registers, the enable and command handovers into
 * the timer domain, clock source choice and prescalers, compare write
 * mirroring and the output override and routing stage.
 * Assumes an APB master on sys_clk, a ramp engine on sys_clk that reports
 * cycle end, phase and default waveform levels, and clock sources that
 * arrive as plain levels to be sampled.
 */
`timescale 1ns/10ps
`default_nettype none

// Function
// - clock source code 0 internal oscillator, 2 external clock, 3 system clock
// - counter divider code 0,1,2 divides counter clock by 1, 4, 32
// - handover divider codes 0..3 divide timer clock by 1, 2, 4, 8
// - enable passes a synchroniser; timer runs only on the synchronised value
// - clock and divider fields writable only while disabled; enable writable except while an enable handover is pending
// - mode code 0 one-ramp, 1 two-ramp, 2 four-ramp, 3 dual-slope
// - outputs C and D carry waveform A on zero, waveform B on one
// - fifty-percent bit mirrors compare B set/clear writes into compare A
// - auto-update: writing compare B clear high requests end-of-cycle load
// - fifty plus auto-update: writing compare A clear high requests load too
// - override bit makes waveforms A and B take per-phase nibble levels
// - low nibble is A, high nibble B; bits 0..3 are DEAD_TIME_A, ON_TIME_A, DEAD_TIME_B, ON_TIME_B
// - one-ramp: A uses bit1 dead, bit0 on; B uses bit3 dead, bit2 on
// - stop strobe disables timer at cycle end; enable idle low until then
// - stop strobe ignored while an enable handover is in progress
// - capture strobes copy counter to capture A or B after handover
// - restart strobe restarts counter once it reaches timer domain
// - immediate load strobe loads buffered registers once handed over
// - end-of-cycle load strobe loads buffered registers at next cycle end
// - command strobes ignored while an earlier command is being handed over
module pwmctl_top
	import pwmctl_pkg::*;
#(
	parameter int HANDOVER_TICKS = HANDOVER_STAGES
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        fast_osc_in,
	input  wire logic        ext_clk_in,
	input  wire logic        cycle_end,
	input  wire logic [1:0]  phase,
	input  wire logic        wave_a_in,
	input  wire logic        wave_b_in,
	output logic             timer_tick,
	output logic             counter_tick,
	output logic             timer_running,
	output pwmctl_mode_t     waveform_mode,
	output logic             waveform_output_a,
	output logic             waveform_output_b,
	output logic             waveform_output_c,
	output logic             waveform_output_d,
	output logic             capture_a_pulse,
	output logic             capture_b_pulse,
	output logic             restart_pulse,
	output logic             buffer_load_pulse,
	output logic [7:0]       cmp_wr_strobe,
	output logic [7:0]       cmp_wr_data
);

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic [5:0] idx;
	logic       wr_en;
	logic       mapped;
	logic       is_cmp;
	logic [2:0] cmp_sel;
	logic [7:0] wbyte;

	assign idx     = paddr[7:2];
	assign wbyte   = pwdata[7:0];
	assign is_cmp  = (idx >= IDX_CMP_FIRST) && (idx <= IDX_CMP_LAST);
	assign cmp_sel = idx[2:0];
	assign mapped  = (idx <= IDX_COMMAND_STROBE) || (idx == IDX_STATUS) || is_cmp;
	assign wr_en   = psel && penable && pwrite && mapped;
	// zero wait states; errors only on unmapped addresses
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic           enable_reg;
	pwmctl_source_t clock_source_field;
	logic [1:0]     counter_divider_field;
	logic [1:0]     handover_divider_field;
	pwmctl_mode_t   mode_reg;
	logic           output_d_route;
	logic           output_c_route;
	logic           fifty_reg;
	logic           auto_load_request;
	logic           output_level_override;
	logic [3:0]     waveform_a_override_nibble;
	logic [3:0]     waveform_b_override_nibble;
	logic [CMD_WIDTH-1:0] cmd_reg;
	logic           stop_at_cycle_end;
	logic           timer_enable_reg;
	logic           en_pending_reg;
	logic           eoc_armed_reg;
	logic           enable_handover_idle;
	logic           command_handover_idle;
	logic           stop_done;
	logic           cmd_accept;

	assign enable_handover_idle  = !en_pending_reg && !stop_at_cycle_end;
	assign command_handover_idle = (cmd_reg == '0) && !eoc_armed_reg;
	assign stop_done = stop_at_cycle_end && cycle_end && timer_enable_reg;

	// enable bit: a write during a running handover is dropped to keep the
	// two domains from disagreeing
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			enable_reg <= 1'b0;
		end else if (stop_done) begin
			enable_reg <= 1'b0;
		end else if (wr_en && idx == IDX_CLOCK_ENABLE && !en_pending_reg) begin
			enable_reg <= wbyte[ENABLE_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			clock_source_field     <= internal_fast_oscillator;
			counter_divider_field  <= CNT_DIV1;
			handover_divider_field <= 2'h0;
		end else if (wr_en && idx == IDX_CLOCK_ENABLE && !enable_reg && !timer_enable_reg) begin
			clock_source_field     <= pwmctl_source_t'(wbyte[SOURCE_LSB +: 2]);
			counter_divider_field  <= wbyte[COUNTER_LSB +: 2];
			handover_divider_field <= wbyte[HANDOVER_LSB +: 2];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mode_reg <= single_ramp_mode;
		end else if (wr_en && idx == IDX_WAVEFORM_MODE) begin
			mode_reg <= pwmctl_mode_t'(wbyte[1:0]);
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			output_d_route        <= 1'b0;
			output_c_route        <= 1'b0;
			fifty_reg             <= 1'b0;
			auto_load_request     <= 1'b0;
			output_level_override <= 1'b0;
		end else if (wr_en && idx == IDX_OUTPUT_ROUTE) begin
			output_d_route        <= wbyte[ROUTE_D_BIT];
			output_c_route        <= wbyte[ROUTE_C_BIT];
			fifty_reg             <= wbyte[FIFTY_BIT];
			auto_load_request     <= wbyte[AUTO_LOAD_BIT];
			output_level_override <= wbyte[OVERRIDE_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			waveform_a_override_nibble <= 4'h0;
			waveform_b_override_nibble <= 4'h0;
		end else if (wr_en && idx == IDX_OVERRIDE_VALUE) begin
			waveform_a_override_nibble <= wbyte[3:0];
			waveform_b_override_nibble <= wbyte[7:4];
		end
	end

	// ------------------------------------------------------------
	// read path, registered during the setup cycle
	// ------------------------------------------------------------
	logic [7:0] rbyte;

	always_comb begin
		rbyte = REG_RESET;
		case (idx)
			IDX_CLOCK_ENABLE: begin
				rbyte[ENABLE_BIT]          = enable_reg;
				rbyte[HANDOVER_LSB +: 2]   = handover_divider_field;
				rbyte[COUNTER_LSB +: 2]    = counter_divider_field;
				rbyte[SOURCE_LSB +: 2]     = clock_source_field;
			end
			IDX_WAVEFORM_MODE: begin
				rbyte[1:0] = mode_reg;
			end
			IDX_OUTPUT_ROUTE: begin
				rbyte[ROUTE_D_BIT]   = output_d_route;
				rbyte[ROUTE_C_BIT]   = output_c_route;
				rbyte[FIFTY_BIT]     = fifty_reg;
				rbyte[AUTO_LOAD_BIT] = auto_load_request;
				rbyte[OVERRIDE_BIT]  = output_level_override;
			end
			IDX_OVERRIDE_VALUE: begin
				rbyte = {waveform_b_override_nibble, waveform_a_override_nibble};
			end
			IDX_COMMAND_STROBE: begin
				rbyte[STOP_EOC_BIT]  = stop_at_cycle_end;
				rbyte[CMD_WIDTH-1:0] = cmd_reg;
			end
			IDX_STATUS: begin
				rbyte[STAT_EN_IDLE]  = enable_handover_idle;
				rbyte[STAT_CMD_IDLE] = command_handover_idle;
			end
			default: begin
				rbyte = REG_RESET;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= '0;
		end else if (psel && !penable) begin
			prdata <= {24'h00_0000, rbyte};
		end
	end

	// ------------------------------------------------------------
	// clock source and prescalers
	// ------------------------------------------------------------
	logic [2:0] osc_sync;
	logic [2:0] ext_sync;
	logic       source_tick;
	logic [2:0] hand_div;
	logic [4:0] cnt_div;
	logic       hand_hit;

	// two flops before use; the third only delays for edge detection
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			osc_sync <= 3'h0;
			ext_sync <= 3'h0;
		end else begin
			osc_sync <= {osc_sync[1:0], fast_osc_in};
			ext_sync <= {ext_sync[1:0], ext_clk_in};
		end
	end

	always_comb begin
		case (clock_source_field)
			internal_fast_oscillator: source_tick = osc_sync[1] && !osc_sync[2];
			external_clock_input:     source_tick = ext_sync[1] && !ext_sync[2];
			system_clock_source:      source_tick = 1'b1;
			default:                  source_tick = 1'b0;
		endcase
	end

	// handover divider: 1, 2, 4 or 8 source ticks per timer tick
	always_comb begin
		case (handover_divider_field)
			2'h0:    hand_hit = 1'b1;
			2'h1:    hand_hit = hand_div[0];
			2'h2:    hand_hit = &hand_div[1:0];
			default: hand_hit = &hand_div;
		endcase
	end

	assign timer_tick = source_tick && hand_hit;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hand_div <= 3'h0;
		end else if (source_tick) begin
			hand_div <= hand_hit ? 3'h0 : hand_div + 3'h1;
		end
	end

	logic cnt_hit;

	always_comb begin
		case (counter_divider_field)
			CNT_DIV1:  cnt_hit = 1'b1;
			CNT_DIV4:  cnt_hit = cnt_div >= CNT_LAST4;
			CNT_DIV32: cnt_hit = cnt_div >= CNT_LAST32;
			default:   cnt_hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_div <= 5'h00;
		end else if (timer_tick) begin
			cnt_div <= cnt_hit ? 5'h00 : cnt_div + 5'h01;
		end
	end

	assign timer_running = timer_enable_reg;
	assign counter_tick  = timer_tick && cnt_hit && timer_enable_reg;

	// ------------------------------------------------------------
	// enable handover and stop at cycle end
	// ------------------------------------------------------------
	logic [3:0] en_cnt;
	logic       en_arrive;

	assign en_arrive = en_pending_reg && timer_tick && (en_cnt >= 4'(HANDOVER_TICKS - 1));

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			en_pending_reg <= 1'b0;
		end else if (wr_en && idx == IDX_CLOCK_ENABLE && !en_pending_reg
			&& wbyte[ENABLE_BIT] != enable_reg) begin
			en_pending_reg <= 1'b1;
		end else if (en_arrive) begin
			en_pending_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			en_cnt <= 4'h0;
		end else if (!en_pending_reg || en_arrive) begin
			en_cnt <= 4'h0;
		end else if (timer_tick) begin
			en_cnt <= en_cnt + 4'h1;
		end
	end

	// timer side copy of enable; only this is used to run the timer
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			timer_enable_reg <= 1'b0;
		end else if (stop_done) begin
			timer_enable_reg <= 1'b0;
		end else if (en_arrive) begin
			timer_enable_reg <= enable_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			stop_at_cycle_end <= 1'b0;
		end else if (stop_done || !timer_enable_reg) begin
			stop_at_cycle_end <= 1'b0;
		end else if (wr_en && idx == IDX_COMMAND_STROBE && wbyte[STOP_EOC_BIT]
			&& !en_pending_reg) begin
			stop_at_cycle_end <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// command strobes
	// ------------------------------------------------------------
	logic [3:0] cmd_cnt;
	logic       auto_load;
	logic       cmd_write;

	assign cmd_write  = wr_en && idx == IDX_COMMAND_STROBE && command_handover_idle;
	assign cmd_accept = (cmd_reg != '0) && timer_tick && (cmd_cnt >= 4'(HANDOVER_TICKS - 1));
	assign auto_load  = wr_en && is_cmp && auto_load_request
		&& ((cmp_sel == CMP_B_CLEAR_HIGH)
		|| (fifty_reg && cmp_sel == CMP_A_CLEAR_HIGH));

	// a new request only lands while idle, so accept and set never collide,
	// except the auto request, which is ORed in after the clear
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_reg <= '0;
		end else begin
			if (cmd_accept) begin
				cmd_reg <= '0;
			end else if (cmd_write) begin
				cmd_reg <= wbyte[CMD_WIDTH-1:0];
			end
			if (auto_load) begin
				cmd_reg[CMD_EOC_LOAD] <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_cnt <= 4'h0;
		end else if (cmd_reg == '0 || cmd_accept) begin
			cmd_cnt <= 4'h0;
		end else if (timer_tick) begin
			cmd_cnt <= cmd_cnt + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			eoc_armed_reg <= 1'b0;
		end else if (cmd_accept && cmd_reg[CMD_EOC_LOAD]) begin
			eoc_armed_reg <= 1'b1;
		end else if (cycle_end) begin
			eoc_armed_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			capture_a_pulse   <= 1'b0;
			capture_b_pulse   <= 1'b0;
			restart_pulse     <= 1'b0;
			buffer_load_pulse <= 1'b0;
		end else begin
			capture_a_pulse   <= cmd_accept && cmd_reg[CMD_CAPTURE_A];
			capture_b_pulse   <= cmd_accept && cmd_reg[CMD_CAPTURE_B];
			restart_pulse     <= cmd_accept && cmd_reg[CMD_RESTART];
			buffer_load_pulse <= (cmd_accept && cmd_reg[CMD_LOAD_NOW])
				|| (eoc_armed_reg && cycle_end);
		end
	end

	// ------------------------------------------------------------
	// compare writes with mirroring
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cmp_wr_strobe <= 8'h00;
			cmp_wr_data   <= 8'h00;
		end else begin
			cmp_wr_strobe <= 8'h00;
			if (wr_en && is_cmp) begin
				cmp_wr_data            <= wbyte;
				cmp_wr_strobe[cmp_sel] <= 1'b1;
				if (fifty_reg && cmp_sel >= CMP_B_OFFSET) begin
					cmp_wr_strobe[cmp_sel - CMP_B_OFFSET] <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// output override and routing
	// ------------------------------------------------------------
	logic level_a;
	logic level_b;

	always_comb begin
		level_a = wave_a_in;
		level_b = wave_b_in;
		if (output_level_override) begin
			if (mode_reg == single_ramp_mode) begin
				case (phase)
					PHASE_DEAD_A: level_a = waveform_a_override_nibble[1];
					PHASE_ON_A:   level_a = waveform_a_override_nibble[0];
					PHASE_DEAD_B: level_b = waveform_b_override_nibble[3];
					PHASE_ON_B:   level_b = waveform_b_override_nibble[2];
					default:      level_a = wave_a_in;
				endcase
			end else begin
				level_a = waveform_a_override_nibble[phase];
				level_b = waveform_b_override_nibble[phase];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			waveform_output_a <= 1'b0;
			waveform_output_b <= 1'b0;
			waveform_output_c <= 1'b0;
			waveform_output_d <= 1'b0;
		end else begin
			waveform_output_a <= level_a;
			waveform_output_b <= level_b;
			waveform_output_c <= output_c_route ? level_b : level_a;
			waveform_output_d <= output_d_route ? level_b : level_a;
		end
	end

	assign waveform_mode = mode_reg;

endmodule
`default_nettype wire

// ===== shared/pwmctl_pkg.sv
/*
 * pwmctl_pkg: register indices, field positions, codes and handover
 * constants for the waveform timer control-register front end.
 * Assumes registers sit on a 32-bit APB, one register per aligned word,
 * byte address = index * 4.
 */
package pwmctl_pkg;

	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_CLOCK_ENABLE   = 6'h00;
	localparam logic [5:0] IDX_WAVEFORM_MODE  = 6'h01;
	localparam logic [5:0] IDX_OUTPUT_ROUTE   = 6'h02;
	localparam logic [5:0] IDX_OVERRIDE_VALUE = 6'h03;
	localparam logic [5:0] IDX_COMMAND_STROBE = 6'h04;
	localparam logic [5:0] IDX_STATUS         = 6'h0E;
	localparam logic [5:0] IDX_CMP_FIRST      = 6'h28;
	localparam logic [5:0] IDX_CMP_LAST       = 6'h2F;
	localparam logic [2:0] CMP_A_CLEAR_HIGH   = 3'h3;
	localparam logic [2:0] CMP_B_CLEAR_HIGH   = 3'h7;
	localparam logic [2:0] CMP_B_OFFSET       = 3'h4;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int ENABLE_BIT     = 0;
	localparam int HANDOVER_LSB   = 1;
	localparam int COUNTER_LSB    = 3;
	localparam int SOURCE_LSB     = 5;
	localparam int OVERRIDE_BIT   = 0;
	localparam int AUTO_LOAD_BIT  = 1;
	localparam int FIFTY_BIT      = 3;
	localparam int ROUTE_C_BIT    = 6;
	localparam int ROUTE_D_BIT    = 7;
	localparam int STOP_EOC_BIT   = 7;
	localparam int CMD_EOC_LOAD   = 0;
	localparam int CMD_LOAD_NOW   = 1;
	localparam int CMD_RESTART    = 2;
	localparam int CMD_CAPTURE_A  = 3;
	localparam int CMD_CAPTURE_B  = 4;
	localparam int CMD_WIDTH      = 5;
	localparam int STAT_EN_IDLE   = 0;
	localparam int STAT_CMD_IDLE  = 1;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		internal_fast_oscillator = 2'h0,
		source_reserved          = 2'h1,
		external_clock_input     = 2'h2,
		system_clock_source      = 2'h3
	} pwmctl_source_t;

	typedef enum logic [1:0] {
		single_ramp_mode  = 2'h0,
		double_ramp_mode  = 2'h1,
		quad_ramp_mode    = 2'h2,
		up_down_slope_mode = 2'h3
	} pwmctl_mode_t;

	// cycle phase reported by the ramp engine
	localparam logic [1:0] PHASE_DEAD_A = 2'h0;
	localparam logic [1:0] PHASE_ON_A   = 2'h1;
	localparam logic [1:0] PHASE_DEAD_B = 2'h2;
	localparam logic [1:0] PHASE_ON_B   = 2'h3;

	// counter divider codes and their terminal counts
	localparam logic [1:0] CNT_DIV1  = 2'h0;
	localparam logic [1:0] CNT_DIV4  = 2'h1;
	localparam logic [1:0] CNT_DIV32 = 2'h2;
	localparam logic [4:0] CNT_LAST4  = 5'h03;
	localparam logic [4:0] CNT_LAST32 = 5'h1F;

	// timer ticks a value needs to cross into the timer domain
	localparam int HANDOVER_STAGES = 2;

endpackage

// ===== verification/pwm_timer_control_registers_tb_top.sv
/*
 * Testbench for pwmctl_top: APB register sequences with expected values.
 * Assumes the bound checker; the bench plays the ramp engine and sources.
 */
`timescale 1ns/10ps
`default_nettype none
module pwm_timer_control_registers_tb_top
	import pwmctl_pkg::*;
;
	logic         sys_clk, pready, pslverr, timer_tick, counter_tick, timer_running;
	logic         nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, cycle_end = 1'h0;
	logic         fast_osc_in = 1'h0, ext_clk_in = 1'h0, wave_a_in = 1'h1, wave_b_in = 1'h0;
	logic         waveform_output_a, waveform_output_b, waveform_output_c, waveform_output_d;
	logic         capture_a_pulse, capture_b_pulse, restart_pulse, buffer_load_pulse;
	logic [1:0]   phase = 2'h0, osc_div = 2'h0;
	logic [7:0]   paddr = 8'h00, cmp_wr_strobe, cmp_wr_data, strb_acc = 8'h00;
	logic [31:0]  pwdata = 32'h0000_0000, prdata, rv;
	logic [1:0]   lvl;
	pwmctl_mode_t waveform_mode;
	int           num_errors = 0, samples_checked = 0, i, k, p, n;
	int           pcnt [4] = '{0, 0, 0, 0};
	logic [7:0]   cfg [7] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h62, 8'h64, 8'h66};
	int           ex [7] = '{16, 0, 8, 32, 16, 8, 4};

	pwmctl_top #(.HANDOVER_TICKS(2)) u_dut (.sys_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .fast_osc_in, .ext_clk_in, .cycle_end, .phase, .wave_a_in, .wave_b_in,
		.timer_tick, .counter_tick, .timer_running, .waveform_mode, .waveform_output_a, .waveform_output_b,
		.waveform_output_c, .waveform_output_d, .capture_a_pulse, .capture_b_pulse, .restart_pulse,
		.buffer_load_pulse, .cmp_wr_strobe, .cmp_wr_data);

	// ------------------------------------------------------------
	// clock, sources and pulse monitors
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		osc_div <= osc_div + 2'h1;
		fast_osc_in <= osc_div[0];
		ext_clk_in <= osc_div[1];
		pcnt[0] <= pcnt[0] + buffer_load_pulse;
		pcnt[1] <= pcnt[1] + restart_pulse;
		pcnt[2] <= pcnt[2] + capture_a_pulse;
		pcnt[3] <= pcnt[3] + capture_b_pulse;
		strb_acc <= strb_acc | cmp_wr_strobe;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] v);
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge sys_clk);
		penable <= 1'h1;
		do @(posedge sys_clk); while (pready !== 1'h1);
		v = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'h1, a, d, rv);
	endtask
	task rd(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 8'h00, rv);
		chk(s, e, rv);
	endtask
	// enable changes only once the previous handover is over
	task wait_idle;
		repeat (100) begin
			apb(1'h0, 8'h38, 8'h00, rv);
			if (rv[0] === 1'h1)
				break;
		end
	endtask
	task eoc(input string s, input int e);
		repeat (40) @(posedge sys_clk);
		cycle_end <= 1'h1;
		@(posedge sys_clk);
		cycle_end <= 1'h0;
		repeat (3) @(posedge sys_clk);
		chk(s, e, pcnt[0]);
		@(negedge sys_clk) pcnt = '{0, 0, 0, 0};
	endtask
	task cnt(input int len, input logic sel, output int c);
		c = 0;
		repeat (len) begin
			@(negedge sys_clk);
			c += sel ? counter_tick : timer_tick;
		end
	endtask
	// override nibbles a = 0110, b = 1001; defaults a = 1, b = 0
	function automatic logic [1:0] lv(input int i, input int p);
		logic [3:0] na = 4'h6;
		logic [3:0] nb = 4'h9;
		logic       a = 1'h1;
		logic       b = 1'h0;
		if (i == 4 && p < 2)
			a = na[1 - p];
		else if (i == 4)
			b = nb[5 - p];
		else if (i > 4) begin
			a = na[p];
			b = nb[p];
		end
		return {b, a};
	endfunction

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (30000) @(posedge sys_clk);
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		nrst <= 1'h1;
		for (i = 0; i < 5; i++)
			rd("reg reset", 8'(i * 4), 0);
		rd("status reset", 8'h38, 3);
		rd("unmapped read", 8'h14, 0);
		$display("test reset done");
		for (i = 0; i < 7; i++) begin
			wr(8'h00, cfg[i]);
			rd("ctrl fields", 8'h00, cfg[i]);
			repeat (4) @(posedge sys_clk);
			cnt(32, 1'h0, n);
			chk("timer ticks", ex[i], n);
		end
		wr(8'h00, 8'h69);
		wait_idle();
		chk("running", 1, timer_running);
		cnt(64, 1'h1, n);
		chk("counter ticks", 16, n);
		wr(8'h00, 8'h61);
		rd("locked fields", 8'h00, 8'h69);
		wr(8'h10, 8'h80);
		rd("stop pending", 8'h38, 2);
		eoc("stop load", 0);
		chk("stopped", 0, timer_running);
		rd("stopped ctrl", 8'h00, 8'h68);
		wr(8'h00, 8'h67);
		wr(8'h10, 8'h80);
		wait_idle();
		eoc("load", 0);
		chk("stop ignored", 1, timer_running);
		$display("test enable done");
		for (k = 1; k < 5; k++) begin
			wr(8'h10, 8'(1 << k));
			wr(8'h10, 8'(1 << (k % 4 + 1)));
			rd("cmd pending", 8'h10, 1 << k);
			repeat (40) @(posedge sys_clk);
			rd("cmd cleared", 8'h10, 0);
			for (i = 0; i < 4; i++)
				chk("cmd pulses", i == k - 1, pcnt[i]);
			@(negedge sys_clk) pcnt = '{0, 0, 0, 0};
		end
		wr(8'h10, 8'h01);
		eoc("eoc load", 1);
		wr(8'h08, 8'h02);
		wr(8'hBC, 8'h5A);
		eoc("auto load", 1);
		wr(8'hAC, 8'h5A);
		eoc("no fifty load", 0);
		wr(8'h08, 8'h0A);
		wr(8'hAC, 8'h3C);
		eoc("fifty load", 1);
		@(negedge sys_clk) strb_acc = 8'h00;
		wr(8'hB0, 8'h3C);
		repeat (2) @(posedge sys_clk);
		chk("mirror strobe", 8'h11, strb_acc);
		wr(8'hA0, 8'h3C);
		$display("test command done");
		wr(8'h0C, 8'h96);
		for (i = 0; i < 8; i++) begin
			wr(8'h08, i > 3 ? 8'h41 : 8'h40);
			wr(8'h04, 8'(i % 4));
			@(negedge sys_clk);
			chk("mode", i % 4, waveform_mode);
			for (p = 0; p < 4; p++) begin
				@(posedge sys_clk);
				phase <= 2'(p);
				repeat (2) @(negedge sys_clk);
				lvl = lv(i, p);
				chk("out a", lvl[0], waveform_output_a);
				chk("out b", lvl[1], waveform_output_b);
				chk("out c", lvl[1], waveform_output_c);
				chk("out d", lvl[0], waveform_output_d);
			end
		end
		$display("test override done");
		end_sim();
	end
endmodule
`default_nettype wire

// ===== verification/pwmctl_top_assertions.sv
/*
 * pwmctl_top_assertions: port-level checks of the control front end.
 * Assumes it is bound onto pwmctl_top, with sys_clk as the only clock.
 */
`timescale 1ns/10ps
`default_nettype none
module pwmctl_top_assertions
	import pwmctl_pkg::*;
(
	input wire logic         sys_clk,
	input wire logic         nrst,
	input wire logic [7:0]   paddr,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [31:0]  pwdata,
	input wire logic         pslverr,
	input wire logic         cycle_end,
	input wire logic         timer_tick,
	input wire logic         counter_tick,
	input wire logic         timer_running,
	input wire pwmctl_mode_t waveform_mode,
	input wire logic         waveform_output_a,
	input wire logic         waveform_output_b,
	input wire logic         waveform_output_c,
	input wire logic         waveform_output_d,
	input wire logic         restart_pulse,
	input wire logic [7:0]   cmp_wr_strobe,
	input wire logic [7:0]   cmp_wr_data
);
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	wire logic bus_wr = psel && penable && pwrite;

	a_unmapped_err: assert property (psel && penable && paddr[7:2] == 6'h05 |-> pslverr)
		else $error("no error on unmapped access");
	a_mapped_ok: assert property (psel && penable && paddr[7:2] == 6'h00 |-> !pslverr)
		else $error("error on mapped access");
	a_route_c: assert property (waveform_output_c == waveform_output_a || waveform_output_c == waveform_output_b)
		else $error("output c carries neither waveform");
	a_route_d: assert property (waveform_output_d == waveform_output_a || waveform_output_d == waveform_output_b)
		else $error("output d carries neither waveform");
	a_counter_gate: assert property (counter_tick |-> timer_running && timer_tick)
		else $error("counter tick without running timer tick");
	// running may only move on a timer tick or at cycle end
	a_run_tick: assert property ($changed(timer_running) |-> $past(timer_tick || cycle_end))
		else $error("timer run state moved off a tick");
	a_mode_write: assert property ($changed(waveform_mode) |-> $past(bus_wr && paddr[7:2] == 6'h01))
		else $error("mode changed without a write");
	a_cmp_b_high: assert property (bus_wr && paddr[7:2] == 6'h2F |=>
		cmp_wr_strobe[7] && cmp_wr_data == $past(pwdata[7:0]))
		else $error("compare write not passed on");
	a_cmp_a_only: assert property (bus_wr && paddr[7:2] == 6'h28 |=> cmp_wr_strobe == 8'h01)
		else $error("compare a write strobed other bytes");
	a_restart_pulse: assert property (restart_pulse |=> !restart_pulse)
		else $error("restart pulse longer than one cycle");
endmodule

bind pwmctl_top pwmctl_top_assertions u_chk (.sys_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata,
	.pslverr, .cycle_end, .timer_tick, .counter_tick, .timer_running, .waveform_mode, .waveform_output_a,
	.waveform_output_b, .waveform_output_c, .waveform_output_d, .restart_pulse, .cmp_wr_strobe, .cmp_wr_data);
`default_nettype wire
